// File: logic/mccap_pkg.sv
// multicast capability register bank: offsets, field positions, reset values
// assumes a dword-wide configuration access port on the core clock
package mccap_pkg;
  localparam logic [11:0] MCCAP_HDR_OFS = 12'h900;
  localparam logic [11:0] MCCAP_CAPCTL_OFS = 12'h904;
  localparam logic [11:0] MCCAP_BASELO_OFS = 12'h908;
  localparam logic [11:0] MCCAP_BASEHI_OFS = 12'h90c;
  localparam logic [15:0] MCCAP_CAP_ID = 16'h0012;
  localparam logic [3:0] MCCAP_CAP_VER = 4'h1;
  localparam logic [11:0] MCCAP_NEXT_PTR = 12'h000;
  localparam logic [5:0] MCCAP_GROUP_LIMIT_RST = 6'h01;
  localparam logic MCCAP_CRC_REGEN_RST = 1'b0;
  localparam int MCCAP_GROUP_LIMIT_LSB = 0;
  localparam int MCCAP_CRC_REGEN_BIT = 15;
  localparam int MCCAP_GROUP_COUNT_BIT = 16;
  localparam int MCCAP_ENABLE_BIT = 31;
  localparam int MCCAP_LSB_POS_LSB = 0;
  localparam int MCCAP_BASE_LSB = 12;
  localparam logic MCCAP_GROUP_COUNT_RST = 1'b0;
  localparam logic MCCAP_ENABLE_RST = 1'b0;
  localparam logic [5:0] MCCAP_LSB_POS_RST = 6'h00;
  localparam logic [51:0] MCCAP_BASE_RST = 52'h0;
endpackage

// File: logic/mccap_match.sv
// multicast window hit and group number extraction
// assumes registered inputs from the register bank
`timescale 1ns/10ps
module mccap_match #(
  parameter int GROUP_WIDTH = 6
) (
  input wire logic enable,
  input wire logic [51:0] windowBase,
  input wire logic [5:0] lsbPosition,
  input wire logic [63:0] address,
  output logic hit,
  output logic [GROUP_WIDTH-1:0] groupNumber
);
  logic [63:0] shifted;
  always_comb begin
    shifted = address >> lsbPosition;
    hit = enable && (address[63:12] >= windowBase);
    groupNumber = shifted[GROUP_WIDTH-1:0];
  end
endmodule // mccap_match

// File: logic/mccap_regs.sv
// multicast capability registers with a dword config port and a window check
// assumes config requests and addresses are synchronous to ref_clk
`timescale 1ns/10ps
module mccap_regs #(
  parameter logic [5:0] GROUP_LIMIT = mccap_pkg::MCCAP_GROUP_LIMIT_RST,
  parameter int GROUP_WIDTH = 6
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [11:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWriteData,
  output logic [31:0] cfgReadData,
  output logic cfgReadValid,
  input wire logic [63:0] checkAddr,
  output logic multicastEnable,
  output logic [51:0] groupWindowBase,
  output logic [5:0] groupNumberLsbPosition,
  output logic configuredGroupCount,
  output logic groupHit,
  output logic [GROUP_WIDTH-1:0] groupNumber
);
  logic enable_q, enable_d;
  logic groupCount_q, groupCount_d;
  logic [5:0] lsbPos_q, lsbPos_d;
  logic [51:0] base_q, base_d;
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic hit_q, hit_d;
  logic [GROUP_WIDTH-1:0] group_q, group_d;
  logic [31:0] capCtl;
  logic matchHit;
  logic [GROUP_WIDTH-1:0] matchGroup;

  mccap_match #(.GROUP_WIDTH(GROUP_WIDTH)) u_match (
    .enable(enable_q),
    .windowBase(base_q),
    .lsbPosition(lsbPos_q),
    .address(checkAddr),
    .hit(matchHit),
    .groupNumber(matchGroup)
  );

  always_comb begin
    capCtl = 32'h0;
    capCtl[mccap_pkg::MCCAP_GROUP_LIMIT_LSB +: 6] = GROUP_LIMIT;
    capCtl[mccap_pkg::MCCAP_CRC_REGEN_BIT] = mccap_pkg::MCCAP_CRC_REGEN_RST;
    capCtl[mccap_pkg::MCCAP_GROUP_COUNT_BIT] = groupCount_q;
    capCtl[mccap_pkg::MCCAP_ENABLE_BIT] = enable_q;
  end

  always_comb begin
    enable_d = enable_q;
    groupCount_d = groupCount_q;
    lsbPos_d = lsbPos_q;
    base_d = base_q;
    if (cfgWrite) begin
      unique case (cfgAddr)
        mccap_pkg::MCCAP_CAPCTL_OFS: begin
          if (cfgByteEn[2]) groupCount_d = cfgWriteData[mccap_pkg::MCCAP_GROUP_COUNT_BIT];
          if (cfgByteEn[3]) enable_d = cfgWriteData[mccap_pkg::MCCAP_ENABLE_BIT];
        end
        mccap_pkg::MCCAP_BASELO_OFS: begin
          if (cfgByteEn[0]) lsbPos_d = cfgWriteData[5:0];
          if (cfgByteEn[1]) base_d[3:0] = cfgWriteData[15:12];
          if (cfgByteEn[2]) base_d[11:4] = cfgWriteData[23:16];
          if (cfgByteEn[3]) base_d[19:12] = cfgWriteData[31:24];
        end
        mccap_pkg::MCCAP_BASEHI_OFS: begin
          for (int i = 0; i < 4; i++) begin
            if (cfgByteEn[i]) base_d[20+8*i +: 8] = cfgWriteData[8*i +: 8];
          end
        end
        default: begin
        end
      endcase
    end
    rvalid_d = cfgRead;
    rdata_d = 32'h0;
    if (cfgRead) begin
      unique case (cfgAddr)
        mccap_pkg::MCCAP_HDR_OFS:
          rdata_d = {mccap_pkg::MCCAP_NEXT_PTR, mccap_pkg::MCCAP_CAP_VER, mccap_pkg::MCCAP_CAP_ID};
        mccap_pkg::MCCAP_CAPCTL_OFS: rdata_d = capCtl;
        mccap_pkg::MCCAP_BASELO_OFS: rdata_d = {base_q[19:0], 6'h00, lsbPos_q};
        mccap_pkg::MCCAP_BASEHI_OFS: rdata_d = base_q[51:20];
        default: rdata_d = 32'h0;
      endcase
    end
    hit_d = matchHit;
    group_d = matchHit ? matchGroup : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enable_q <= mccap_pkg::MCCAP_ENABLE_RST;
      groupCount_q <= mccap_pkg::MCCAP_GROUP_COUNT_RST;
      lsbPos_q <= mccap_pkg::MCCAP_LSB_POS_RST;
      base_q <= mccap_pkg::MCCAP_BASE_RST;
      rdata_q <= 32'h0;
      rvalid_q <= 1'b0;
      hit_q <= 1'b0;
      group_q <= '0;
    end else begin
      enable_q <= enable_d;
      groupCount_q <= groupCount_d;
      lsbPos_q <= lsbPos_d;
      base_q <= base_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      hit_q <= hit_d;
      group_q <= group_d;
    end
  end

  assign cfgReadData = rdata_q;
  assign cfgReadValid = rvalid_q;
  assign multicastEnable = enable_q;
  assign groupWindowBase = base_q;
  assign groupNumberLsbPosition = lsbPos_q;
  assign configuredGroupCount = groupCount_q;
  assign groupHit = hit_q;
  assign groupNumber = group_q;
endmodule // mccap_regs

// File: test/mccap_regs_properties.sv
// port assertions for the multicast register bank
// bound into mccap_regs
`timescale 1ns/10ps
module mccap_regs_chk (
  input logic ref_clk, srst, cfgWrite, cfgRead, cfgReadValid,
  input logic multicastEnable, configuredGroupCount, groupHit,
  input logic [11:0] cfgAddr,
  input logic [3:0] cfgByteEn,
  input logic [31:0] cfgWriteData, cfgReadData,
  input logic [63:0] checkAddr,
  input logic [51:0] groupWindowBase,
  input logic [5:0] groupNumberLsbPosition
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence hdrRd; cfgRead && cfgAddr == 12'h900; endsequence
  sequence ctlWr; cfgWrite && cfgAddr == 12'h904; endsequence
  hdr_rd_a: assert property (hdrRd |=> cfgReadData == 32'h00010012) else $error("hdr");
  cap_rd_a: assert property (cfgRead && cfgAddr == 12'h904 |=>
    cfgReadData[30:0] == {14'h0, configuredGroupCount, 16'h1}) else $error("cap");
  en_wr_a: assert property (ctlWr ##0 cfgByteEn[3] |=> multicastEnable == $past(cfgWriteData[31])) else $error("en");
  cnt_wr_a: assert property (ctlWr ##0 cfgByteEn[2] |=> configuredGroupCount == $past(cfgWriteData[16]))
    else $error("cnt");
  pos_wr_a: assert property (cfgWrite && cfgAddr == 12'h908 && cfgByteEn[0] |=>
    groupNumberLsbPosition == $past(cfgWriteData[5:0])) else $error("pos");
  base_wr_a: assert property (cfgWrite && cfgAddr == 12'h90c && cfgByteEn == 4'hf |=>
    groupWindowBase[51:20] == $past(cfgWriteData)) else $error("base");
  hit_on_a: assert property (multicastEnable && checkAddr[63:12] >= groupWindowBase |=> groupHit)
    else $error("hit");
  hit_off_a: assert property (!multicastEnable |=> !groupHit) else $error("nohit");
endmodule // mccap_regs_chk
bind mccap_regs mccap_regs_chk chk (.*);

// File: test/mccap_addr_src.sv
// address source standing in for the forwarding logic
// registers the bench address on each rising ref_clk edge
`timescale 1ns/10ps
module mccap_addr_src (
  input logic ref_clk,
  input logic [63:0] nextAddr,
  output logic [63:0] checkAddr = 64'h0
);
  always @(posedge ref_clk) checkAddr <= nextAddr;
endmodule // mccap_addr_src

// File: test/mccap_regs_tb.sv
// self-checking bench for the multicast register bank
// addresses reach the bank through mccap_addr_src
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("unexpected %0t value mismatch", $time); end end
module mccap_regs_tb;
  logic ref_clk = 0, srst = 1, cfgWrite = 0, cfgRead = 0, cfgReadValid, multicastEnable, configuredGroupCount;
  logic groupHit;
  logic [11:0] cfgAddr = 0;
  logic [3:0] cfgByteEn = 0;
  logic [31:0] cfgWriteData = 0, cfgReadData, c, l, h;
  logic [63:0] nextAddr = 0, checkAddr, a;
  logic [51:0] groupWindowBase;
  logic [5:0] groupNumberLsbPosition, groupNumber;
  int failures = 0, num_checks = 0, seed = 41;
  mccap_regs DUT (.*);
  mccap_addr_src src (.*);
  function automatic logic [6:0] eh(logic en, logic [51:0] b, logic [5:0] p, logic [63:0] x);
    logic [63:0] s = x >> p;
    return (en && x[63:12] >= b) ? {1'b1, s[5:0]} : 7'h0;
  endfunction
  task automatic acc(logic w, logic [11:0] ad, logic [31:0] d, logic [3:0] be = 4'hf);
    @(posedge ref_clk);
    {cfgWrite, cfgRead, cfgAddr, cfgWriteData, cfgByteEn} <= {w, !w, ad, d, be};
    @(posedge ref_clk);
    {cfgWrite, cfgRead} <= 2'b0;
    #1 if (!w) `CHK({cfgReadValid, cfgReadData}, {1'b1, d})
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 0;
    acc(0, 12'h900, 32'h00010012);
    acc(0, 12'h904, 32'h1);
    acc(0, 12'h910, 32'h0);
    acc(1, 12'h904, '1);
    acc(0, 12'h904, 32'h80010001);
    acc(1, 12'h90c, '1, 4'h2);
    acc(0, 12'h90c, 32'hff00);
    for (int i = 0; i < 300; i++) begin
      c = $random(seed);
      l = $random(seed);
      h = $random(seed);
      acc(1, 12'h904, c);
      acc(1, 12'h908, l);
      acc(1, 12'h90c, h);
      acc(0, 12'h908, l & 32'hfffff03f);
      `CHK({multicastEnable, configuredGroupCount}, {c[31], c[16]})
      `CHK({groupWindowBase, groupNumberLsbPosition}, {h, l[31:12], l[5:0]})
      // exact base, one below base, or random
      a = {h, l[31:12], 12'h0} - 64'(i % 3);
      if (i % 3 == 2) a = {h, 32'($random(seed))};
      @(posedge ref_clk);
      nextAddr <= a;
      repeat (2) @(posedge ref_clk);
      #1 `CHK({groupHit, groupNumber}, eh(c[31], {h, l[31:12]}, l[5:0], a))
    end
    report_and_stop;
  end
endmodule // mccap_regs_tb
